/* File: design/tmi_slave.sv */
`timescale 1ns/1ns
`include "tmi_defines.svh"

module tmi_slave #(
   parameter logic [`TMI_CNT_W-1:0] TIMEOUT_CYC = 22'(`TMI_TIMEOUT_CYC)
) (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic linkClk,
   input  wire logic sclIn,
   input  wire logic sdaIn,
   output logic      sdaOut,
   output logic      sdaOe,
   output logic      alertOut,
   output logic      alertOe,
   input  wire logic alertCondition,
   input  wire logic alertMode
);

   tmi_pkg::tmi_link_type lk;
   tmi_pkg::tmi_link_type next_lk;
   tmi_pkg::tmi_main_type mk;
   tmi_pkg::tmi_main_type next_mk;

   logic       sclS;
   logic       sdaS;
   logic       rstLink;
   logic       condS;
   logic       modeS;
   logic       toS;
   logic       toEnS;
   logic       actS;
   logic [7:0] rData;
   logic       sclRise;
   logic       sclFall;
   logic       startSeen;
   logic       stopSeen;
   logic       timeoutHit;
   logic       clrReq;
   logic [7:0] loadByte;
   logic       loadClr;

   tmi_sync #(.W(6)) u_linkSync (
      .clk (linkClk),
      .d   ({sclIn, sdaIn, rst, alertCondition, alertMode, mk.toTgl}),
      .q   ({sclS, sdaS, rstLink, condS, modeS, toS})
   );

   tmi_sync #(.W(2)) u_mainSync (
      .clk (mclk),
      .d   ({lk.toEn, lk.actTgl}),
      .q   ({toEnS, actS})
   );

   tmi_regmem u_mem (
      .clk   (linkClk),
      .rst   (rstLink),
      .we    (lk.memWe),
      .wAddr (lk.memAddr),
      .wData (lk.memWd),
      .rAddr (lk.ptr),
      .rData (rData)
   );

   function automatic logic wrOk(input logic [7:0] p);
      return (p >= `TMI_WR_LO && p <= `TMI_WR_HI) ||
             (p >= `TMI_SHARED_LO && p <= `TMI_SHARED_HI);
   endfunction

   function automatic logic [7:0] wrAddr(input logic [7:0] p);
      if (p >= `TMI_WR_LO && p <= `TMI_WR_HI) begin
         return 8'(p - `TMI_WR_OFFSET);
      end
      return p;
   endfunction

   function automatic logic rdHidden(input logic [7:0] p);
      return (p >= `TMI_WR_LO && p <= `TMI_WR_HI) || (p == `TMI_ONESHOT);
   endfunction

   assign sclRise    = sclS & ~lk.sclPrev;
   assign sclFall    = ~sclS & lk.sclPrev;
   assign startSeen  = sclS & lk.sclPrev & lk.sdaPrev & ~sdaS; // R4 R9
   assign stopSeen   = sclS & lk.sclPrev & ~lk.sdaPrev & sdaS; // R9 R10 R11
   assign timeoutHit = lk.toEn & (toS ^ lk.toPrev); // R1

   // Write-only locations read back as zero
   always_comb begin
      loadClr  = 1'b0;
      loadByte = rdHidden(lk.ptr) ? 8'h00 : rData; // R15 R16
      if (lk.isAra) begin
         loadByte = {`TMI_SLAVE_ADDR, 1'b1}; // R19
      end else if (lk.ptr == `TMI_PTR_STATUS) begin
         loadClr = 1'b1; // R23
      end
   end

   always_comb begin
      next_lk         = lk;
      clrReq          = 1'b0;
      next_lk.sclPrev = sclS;
      next_lk.sdaPrev = sdaS;
      next_lk.toPrev  = toS;
      next_lk.memWe   = 1'b0;
      next_lk.actTgl  = lk.actTgl ^ ((sclS ^ lk.sclPrev) | (sdaS ^ lk.sdaPrev));
      if (timeoutHit) begin
         next_lk.st    = tmi_pkg::TMI_IDLE; // R1
         next_lk.sdaOe = 1'b0;
      end else if (startSeen) begin
         next_lk.st     = tmi_pkg::TMI_ADDR; // R5
         next_lk.bitCnt = 4'h0;
         next_lk.sdaOe  = 1'b0;
      end else if (stopSeen) begin
         next_lk.st    = tmi_pkg::TMI_IDLE; // R9
         next_lk.sdaOe = 1'b0;
      end else begin
         unique case (lk.st)
            tmi_pkg::TMI_IDLE: begin
            end
            tmi_pkg::TMI_ADDR: begin
               if (sclRise) begin
                  next_lk.shift  = {lk.shift[6:0], sdaS}; // R5
                  next_lk.bitCnt = 4'(lk.bitCnt + 4'h1);
               end else if (sclFall && lk.bitCnt == `TMI_BITS) begin
                  next_lk.firstByte = 1'b1;
                  if (lk.shift[7:1] == `TMI_SLAVE_ADDR) begin
                     next_lk.st     = tmi_pkg::TMI_ADDR_ACK; // R3 R6
                     next_lk.sdaOe  = 1'b1;
                     next_lk.isRead = lk.shift[0]; // R7
                     next_lk.isAra  = 1'b0;
                  end else if (lk.shift[7:1] == `TMI_ARA_ADDR && lk.shift[0] &&
                               lk.alertLatch) begin
                     next_lk.st     = tmi_pkg::TMI_ADDR_ACK; // R18 R19
                     next_lk.sdaOe  = 1'b1;
                     next_lk.isRead = 1'b1;
                     next_lk.isAra  = 1'b1;
                  end else begin
                     next_lk.st = tmi_pkg::TMI_IDLE; // R6
                  end
               end
            end
            tmi_pkg::TMI_ADDR_ACK: begin
               if (sclFall) begin
                  next_lk.bitCnt = 4'h0;
                  if (lk.isRead) begin
                     next_lk.st     = tmi_pkg::TMI_TX; // R7
                     next_lk.txByte = loadByte;
                     next_lk.sdaOe  = ~loadByte[7];
                     clrReq         = loadClr;
                  end else begin
                     next_lk.st    = tmi_pkg::TMI_RX;
                     next_lk.sdaOe = 1'b0;
                  end
               end
            end
            tmi_pkg::TMI_RX: begin
               if (sclRise) begin
                  next_lk.shift  = {lk.shift[6:0], sdaS};
                  next_lk.bitCnt = 4'(lk.bitCnt + 4'h1);
               end else if (sclFall && lk.bitCnt == `TMI_BITS) begin
                  next_lk.st        = tmi_pkg::TMI_RX_ACK; // R8
                  next_lk.sdaOe     = 1'b1;
                  next_lk.firstByte = 1'b0;
                  if (lk.firstByte) begin
                     next_lk.ptr = lk.shift; // R12 R14 R24
                  end else if (wrOk(lk.ptr)) begin
                     next_lk.memWe   = 1'b1; // R13 R16
                     next_lk.memAddr = wrAddr(lk.ptr);
                     next_lk.memWd   = lk.shift;
                     if (lk.ptr == `TMI_PTR_CONSEC) begin
                        next_lk.toEn = lk.shift[`TMI_TO_EN_BIT]; // R2
                     end
                  end
               end
            end
            tmi_pkg::TMI_RX_ACK: begin
               if (sclFall) begin
                  next_lk.st     = tmi_pkg::TMI_RX;
                  next_lk.bitCnt = 4'h0;
                  next_lk.sdaOe  = 1'b0;
               end
            end
            tmi_pkg::TMI_TX: begin
               if (sclRise) begin
                  if (lk.txByte[7] && !sdaS) begin
                     next_lk.st    = tmi_pkg::TMI_IDLE; // R20
                     next_lk.sdaOe = 1'b0;
                  end else begin
                     next_lk.bitCnt = 4'(lk.bitCnt + 4'h1);
                  end
               end else if (sclFall && lk.bitCnt == `TMI_BITS) begin
                  next_lk.st    = tmi_pkg::TMI_TX_ACK; // R8
                  next_lk.sdaOe = 1'b0;
                  clrReq        = lk.isAra; // R21
               end else if (sclFall) begin
                  next_lk.txByte = {lk.txByte[6:0], 1'b0};
                  next_lk.sdaOe  = ~lk.txByte[6];
               end
            end
            tmi_pkg::TMI_TX_ACK: begin
               if (sclRise) begin
                  next_lk.ackN = sdaS;
               end else if (sclFall) begin
                  next_lk.bitCnt = 4'h0;
                  if (lk.ackN) begin
                     next_lk.st = tmi_pkg::TMI_IDLE; // R11
                  end else begin
                     next_lk.st     = tmi_pkg::TMI_TX;
                     next_lk.txByte = loadByte;
                     next_lk.sdaOe  = ~loadByte[7];
                     clrReq         = loadClr;
                  end
               end
            end
            default: begin
               next_lk.st    = tmi_pkg::TMI_IDLE;
               next_lk.sdaOe = 1'b0;
            end
         endcase
      end
      // A fresh detection outranks a clear in the same cycle
      next_lk.alertLatch = (condS & modeS) | (lk.alertLatch & ~(clrReq & ~condS)); // R17 R21
      next_lk.alertOe    = lk.alertLatch & modeS; // R17
      next_lk.sdaLevel   = 1'b0;
      next_lk.alertLevel = 1'b0;
   end

   always_ff @(posedge linkClk) begin
      if (rstLink) begin
         lk         <= '0;
         lk.st      <= tmi_pkg::TMI_IDLE;
         // Idle bus levels, so no false edge follows reset
         lk.sclPrev <= 1'b1;
         lk.sdaPrev <= 1'b1;
      end else begin
         lk <= next_lk;
      end
   end

   // Counter restarts on every bus edge seen by the link side
   always_comb begin
      next_mk         = mk;
      next_mk.actPrev = actS;
      if (!toEnS || (actS != mk.actPrev)) begin
         next_mk.cnt = '0; // R2
      end else if (mk.cnt == 22'(TIMEOUT_CYC - 22'h1)) begin
         next_mk.cnt   = '0; // R1
         next_mk.toTgl = ~mk.toTgl;
      end else begin
         next_mk.cnt = 22'(mk.cnt + 22'h1);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         mk <= '0;
      end else begin
         mk <= next_mk;
      end
   end

   assign sdaOut   = lk.sdaLevel;
   assign sdaOe    = lk.sdaOe;
   assign alertOut = lk.alertLevel;
   assign alertOe  = lk.alertOe;

   sequence s_stop;
      sclS && lk.sclPrev && !lk.sdaPrev && sdaS;
   endsequence

   sequence s_addr_done;
      lk.st == tmi_pkg::TMI_ADDR && sclFall && lk.bitCnt == `TMI_BITS && !timeoutHit;
   endsequence

   a_stop_idle: assert property (@(posedge linkClk) disable iff (rstLink) // R9
      s_stop and !timeoutHit |=> lk.st == tmi_pkg::TMI_IDLE && !lk.sdaOe)
      else $error("stop did not return to idle");

   a_addr_ack: assert property (@(posedge linkClk) disable iff (rstLink) // R6
      s_addr_done and lk.shift[7:1] == `TMI_SLAVE_ADDR |=>
      lk.st == tmi_pkg::TMI_ADDR_ACK && lk.sdaOe && lk.isRead == $past(lk.shift[0]))
      else $error("matching address not acknowledged");

   a_addr_miss: assert property (@(posedge linkClk) disable iff (rstLink) // R3
      s_addr_done and lk.shift[7:1] != `TMI_SLAVE_ADDR && lk.shift[7:1] != `TMI_ARA_ADDR
      |=> lk.st == tmi_pkg::TMI_IDLE && !lk.sdaOe)
      else $error("foreign address not ignored");

   a_ptr_first: assert property (@(posedge linkClk) disable iff (rstLink) // R12
      lk.st == tmi_pkg::TMI_RX && sclFall && lk.bitCnt == `TMI_BITS && lk.firstByte &&
      !timeoutHit |=> lk.ptr == $past(lk.shift) && !lk.memWe)
      else $error("first write byte not taken as pointer");

   a_data_write: assert property (@(posedge linkClk) disable iff (rstLink) // R13
      lk.st == tmi_pkg::TMI_RX && sclFall && lk.bitCnt == `TMI_BITS && !lk.firstByte &&
      lk.ptr == `TMI_SHARED_LO && !timeoutHit |=> lk.memWe && lk.memAddr == `TMI_SHARED_LO)
      else $error("second write byte not stored");

   a_ara_reply: assert property (@(posedge linkClk) disable iff (rstLink) // R19
      lk.st == tmi_pkg::TMI_ADDR_ACK && sclFall && lk.isAra && !timeoutHit
      |=> lk.txByte == {`TMI_SLAVE_ADDR, 1'b1} && lk.st == tmi_pkg::TMI_TX)
      else $error("alert response byte wrong");

   a_arb_lost: assert property (@(posedge linkClk) disable iff (rstLink) // R20
      lk.st == tmi_pkg::TMI_TX && sclRise && lk.txByte[7] && !sdaS && !timeoutHit &&
      !stopSeen |=> lk.st == tmi_pkg::TMI_IDLE && !lk.sdaOe)
      else $error("lost arbitration but kept driving");

   a_alert_hold: assert property (@(posedge linkClk) disable iff (rstLink) // R21
      lk.alertLatch && condS |=> lk.alertLatch)
      else $error("alert released while condition present");

   a_alert_drive: assert property (@(posedge linkClk) disable iff (rstLink) // R17
      condS && modeS ##1 modeS |=> lk.alertOe)
      else $error("alert output not pulled low");

   a_timeout_idle: assert property (@(posedge linkClk) disable iff (rstLink) // R1
      timeoutHit |=> lk.st == tmi_pkg::TMI_IDLE && !lk.sdaOe)
      else $error("timeout did not release the bus");

   a_timeout_off: assert property (@(posedge mclk) disable iff (rst) // R2
      !toEnS |=> mk.cnt == '0 && $stable(mk.toTgl))
      else $error("timeout counted while disabled");

endmodule

/* File: design/tmi_defines.svh */
// What this block does
// R1 - With timeout enabled, release SDA after 25 ms idle bus, await new start.
// R2 - Timeout is off after reset; bit 7 of register 0x22 turns it on.
// R3 - Ordinary transactions answer only to the fixed 7-bit address 0x4C.
// R4 - Master opens each transfer with SDA falling while SCL is high.
// R5 - After start, shift in seven address bits MSB first, then direction.
// R6 - Acknowledge a matching address by pulling SDA low before ninth pulse.
// R7 - Direction zero means master writes; direction one means master reads.
// R8 - Each byte is eight data bits plus one receiver acknowledge bit.
// R9 - SDA changes only while SCL low; SDA rising during SCL high is stop.
// R10 - Master ends a write by raising SDA during the tenth pulse.
// R11 - Master ends a read with no-acknowledge, then a stop.
// R12 - First byte after address in a write loads the register pointer.
// R13 - A second write byte is stored into the register the pointer selects.
// R14 - Pointer-only write changes no register; next read returns new selection.
// R15 - Read without pointer write returns register of the retained pointer.
// R16 - Split registers take writes at write location, reads at read location.
// R17 - In alert mode, pull alert output low on any out-of-limit detection.
// R18 - Master reads alert response address 0001 100 when the alert line falls.
// R19 - While alert is low, answer that address with own address plus 1.
// R20 - Arbitration decides among responders; a loser keeps its alert asserted.
// R21 - After a won alert response, release alert only if condition cleared.
// R22 - Master repeats alert response reads while the shared line stays low.
// R23 - Reading the status register also clears the alert once condition clears.
// R24 - Pointer keeps its value across stops until the next write changes it.
`ifndef TMI_DEFINES_SVH
`define TMI_DEFINES_SVH

`define TMI_SLAVE_ADDR  7'h4C
`define TMI_ARA_ADDR    7'h0C
`define TMI_PTR_STATUS  8'h02
`define TMI_PTR_CONSEC  8'h22
`define TMI_TO_EN_BIT   7
`define TMI_WR_LO       8'h09
`define TMI_WR_HI       8'h0C
`define TMI_WR_OFFSET   8'h06
`define TMI_ONESHOT     8'h0F
`define TMI_SHARED_LO   8'h20
`define TMI_SHARED_HI   8'h22
`define TMI_BITS        4'h8
`define TMI_TIMEOUT_MS  25
`define TMI_MCLK_KHZ    100000
`define TMI_TIMEOUT_CYC (`TMI_TIMEOUT_MS * `TMI_MCLK_KHZ)
`define TMI_CNT_W       22

`endif

/* File: design/tmi_pkg.sv */
`include "tmi_defines.svh"

package tmi_pkg;

   typedef enum logic [2:0] {
      TMI_IDLE     = 3'h0,
      TMI_ADDR     = 3'h1,
      TMI_ADDR_ACK = 3'h3,
      TMI_RX       = 3'h2,
      TMI_RX_ACK   = 3'h6,
      TMI_TX       = 3'h7,
      TMI_TX_ACK   = 3'h5
   } tmi_state_type;

   typedef struct packed {
      tmi_state_type st;
      logic          sclPrev;
      logic          sdaPrev;
      logic [3:0]    bitCnt;
      logic [7:0]    shift;
      logic          isRead;
      logic          isAra;
      logic          firstByte;
      logic          ackN;
      logic [7:0]    ptr;
      logic [7:0]    txByte;
      logic          sdaOe;
      logic          sdaLevel;
      logic          memWe;
      logic [7:0]    memAddr;
      logic [7:0]    memWd;
      logic          alertLatch;
      logic          alertOe;
      logic          alertLevel;
      logic          toEn;
      logic          toPrev;
      logic          actTgl;
   } tmi_link_type;

   typedef struct packed {
      logic [`TMI_CNT_W-1:0] cnt;
      logic                  toTgl;
      logic                  actPrev;
   } tmi_main_type;

endpackage

/* File: design/tmi_sync.sv */
`timescale 1ns/1ns

module tmi_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } tmi_sync_type;

   tmi_sync_type r;
   tmi_sync_type next_r;

   // No reset: it also carries the reset itself into the link domain
   always_comb begin
      next_r    = r;
      next_r.s1 = d;
      next_r.s2 = r.s1;
   end

   always_ff @(posedge clk) begin
      r <= next_r;
   end

   assign q = r.s2;

endmodule

/* File: design/tmi_regmem.sv */
`timescale 1ns/1ns

module tmi_regmem (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       we,
   input  wire logic [7:0] wAddr,
   input  wire logic [7:0] wData,
   input  wire logic [7:0] rAddr,
   output logic      [7:0] rData
);

   logic [7:0] mem [0:255];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[wAddr] <= wData;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rData <= 8'h00;
      end else begin
         rData <= mem[rAddr];
      end
   end

endmodule

/* File: bench/tmi_master.sv */
`timescale 1ns/1ns

module tmi_master (
   input  wire logic       linkClk,
   input  wire logic       sdaWire,
   output logic            scl,
   output logic            sdaDrv,
   output logic [7:0]      obsByte,
   output logic            obsStrobe
);
   // Quarter bit in link periods, well above the 3-period phase minimum
   localparam int Q = 5;

   initial begin
      scl = 1'b1;
      sdaDrv = 1'b1;
      obsByte = 8'h00;
      obsStrobe = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge linkClk);
   endtask

   // Works from idle and as a repeated start
   task automatic start();
      tick(Q);
      sdaDrv <= 1'b1;
      tick(Q);
      scl <= 1'b1;
      tick(Q);
      sdaDrv <= 1'b0;
      tick(Q);
      scl <= 1'b0;
   endtask

   task automatic stop();
      tick(Q);
      sdaDrv <= 1'b0;
      tick(Q);
      scl <= 1'b1;
      tick(Q);
      sdaDrv <= 1'b1;
   endtask

   task automatic bitx(input logic b, output logic s);
      tick(Q);
      sdaDrv <= b;
      tick(Q);
      scl <= 1'b1;
      tick(Q);
      s = sdaWire;
      tick(Q);
      scl <= 1'b0;
   endtask

   // Read bytes always end in no-acknowledge; the driven bits model a rival responder
   task automatic xfer(input logic [7:0] tx, input logic rd, input logic obs,
                       output logic [7:0] rx);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitx(tx[i], s);
         rx[i] = s;
      end
      bitx(1'b1, s);
      if (obs) begin
         obsByte <= rd ? rx : {7'h00, ~s};
         obsStrobe <= 1'b1;
         tick(1);
         obsStrobe <= 1'b0;
      end
   endtask
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ns
`include "tmi_defines.svh"

module tb_top;
   localparam int TO = 200;
   logic       mclk = 1'b0;
   logic       linkClk = 1'b0;
   logic       rst = 1'b1;
   logic       alertCondition = 1'b0;
   logic       alertMode = 1'b0;
   logic       scl;
   logic       sdaDrv;
   logic       sdaWire;
   logic       sdaOut;
   logic       sdaOe;
   logic       alertOut;
   logic       alertOe;
   logic [7:0] obsByte;
   logic       obsStrobe;
   logic [7:0] expQ[$];
   int         nFail = 0;
   int         checks = 0;

   always #5 mclk = ~mclk;
   always #16 linkClk = ~linkClk;

   // Pull-up wire; an unknown enable counts as released
   assign sdaWire = sdaDrv & ~(sdaOe === 1'b1 && sdaOut === 1'b0);

   tmi_slave #(.TIMEOUT_CYC(22'(TO))) i_dut (
      .mclk(mclk), .rst(rst), .linkClk(linkClk), .sclIn(scl), .sdaIn(sdaWire),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .alertOut(alertOut), .alertOe(alertOe),
      .alertCondition(alertCondition), .alertMode(alertMode)
   );

   tmi_master i_mst (
      .linkClk(linkClk), .sdaWire(sdaWire), .scl(scl), .sdaDrv(sdaDrv),
      .obsByte(obsByte), .obsStrobe(obsStrobe)
   );

   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         nFail++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic endSim();
      $display("checks %0d mismatches %0d", checks, nFail);
      if (nFail == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge linkClk) begin
      if (obsStrobe)
         check("bus byte", obsByte, expQ.size() ? expQ.pop_front() : 8'hXX);
   end

   task automatic wm(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic wr(input logic [6:0] a, input logic ack, input logic [7:0] p,
                     input logic hasD, input logic [7:0] d);
      logic [7:0] r;
      expQ.push_back({7'h00, ack});
      i_mst.start();
      i_mst.xfer({a, 1'b0}, 1'b0, 1'b1, r);
      if (ack) begin
         expQ.push_back(8'h01);
         i_mst.xfer(p, 1'b0, 1'b1, r);
         if (hasD) begin
            expQ.push_back(8'h01);
            i_mst.xfer(d, 1'b0, 1'b1, r);
         end
      end
      i_mst.stop();
   endtask

   task automatic rd(input logic [6:0] a, input logic ack, input logic [7:0] exp,
                     input logic obs, input logic [7:0] rival);
      logic [7:0] r;
      expQ.push_back({7'h00, ack});
      i_mst.start();
      i_mst.xfer({a, 1'b1}, 1'b0, 1'b1, r);
      if (ack) begin
         if (obs)
            expQ.push_back(exp);
         i_mst.xfer(rival, 1'b1, obs, r);
      end
      i_mst.stop();
   endtask

   // Address bits only, leaving the device holding its acknowledge
   task automatic probe();
      logic       s;
      logic [7:0] a;
      a = {`TMI_SLAVE_ADDR, 1'b0};
      i_mst.start();
      for (int i = 7; i >= 0; i--)
         i_mst.bitx(a[i], s);
      i_mst.tick(8);
   endtask

   initial begin
      #1_000_000;
      nFail++;
      endSim();
   end

   initial begin
      logic [7:0] d1;
      logic [7:0] d;
      logic [7:0] p;
      logic [7:0] r;
      logic       s;
      void'($urandom(73));
      // Six main cycles span two link edges of reset
      wm(6);
      rst <= 1'b0;
      wm(20);
      check("sdaOe idle", {7'h00, sdaOe}, 8'h00);
      wr(7'h4D, 1'b0, 8'h00, 1'b0, 8'h00);
      rd(`TMI_ARA_ADDR, 1'b0, 8'h00, 1'b0, 8'hFF);
      $display("test addressing finished");
      d1 = 8'($urandom);
      wr(`TMI_SLAVE_ADDR, 1'b1, 8'h20, 1'b1, d1);
      wr(`TMI_SLAVE_ADDR, 1'b1, 8'h21, 1'b1, ~d1);
      wr(`TMI_SLAVE_ADDR, 1'b1, 8'h20, 1'b0, 8'h00);
      rd(`TMI_SLAVE_ADDR, 1'b1, d1, 1'b1, 8'hFF);
      rd(`TMI_SLAVE_ADDR, 1'b1, d1, 1'b1, 8'hFF);
      // Master acknowledge makes the device send the same register again
      expQ.push_back(8'h01);
      i_mst.start();
      i_mst.xfer({`TMI_SLAVE_ADDR, 1'b1}, 1'b0, 1'b1, r);
      for (int i = 7; i >= 0; i--) begin
         i_mst.bitx(1'b1, s);
         r[i] = s;
      end
      i_mst.bitx(1'b0, s);
      check("acked read", r, d1);
      expQ.push_back(d1);
      i_mst.xfer(8'hFF, 1'b1, 1'b1, r);
      i_mst.stop();
      $display("test pointer finished");
      for (int k = 0; k < 4; k++) begin
         d = 8'($urandom);
         p = `TMI_WR_LO + 8'(k);
         wr(`TMI_SLAVE_ADDR, 1'b1, p, 1'b1, d);
         rd(`TMI_SLAVE_ADDR, 1'b1, 8'h00, 1'b1, 8'hFF);
         wr(`TMI_SLAVE_ADDR, 1'b1, p - `TMI_WR_OFFSET, 1'b0, 8'h00);
         rd(`TMI_SLAVE_ADDR, 1'b1, d, 1'b1, 8'hFF);
      end
      $display("test split registers finished");
      alertCondition <= 1'b1;
      wm(60);
      check("alert gated", {7'h00, alertOe}, 8'h00);
      alertMode <= 1'b1;
      wm(60);
      check("alert set", {7'h00, alertOe}, 8'h01);
      check("alert level", {7'h00, alertOut}, 8'h00);
      rd(`TMI_ARA_ADDR, 1'b1, {`TMI_SLAVE_ADDR, 1'b1}, 1'b1, 8'hFF);
      wm(60);
      check("alert held", {7'h00, alertOe}, 8'h01);
      alertCondition <= 1'b0;
      rd(`TMI_ARA_ADDR, 1'b1, 8'h31, 1'b1, 8'h31);
      wm(60);
      check("alert loser", {7'h00, alertOe}, 8'h01);
      rd(`TMI_ARA_ADDR, 1'b1, {`TMI_SLAVE_ADDR, 1'b1}, 1'b1, 8'hFF);
      wm(60);
      check("alert cleared", {7'h00, alertOe}, 8'h00);
      alertCondition <= 1'b1;
      wm(60);
      alertCondition <= 1'b0;
      check("alert again", {7'h00, alertOe}, 8'h01);
      wr(`TMI_SLAVE_ADDR, 1'b1, `TMI_PTR_STATUS, 1'b0, 8'h00);
      rd(`TMI_SLAVE_ADDR, 1'b1, 8'h00, 1'b0, 8'hFF);
      wm(60);
      check("status clear", {7'h00, alertOe}, 8'h00);
      $display("test alert finished");
      probe();
      check("ack held", {7'h00, sdaOe}, 8'h01);
      wm(3 * TO);
      check("no timeout", {7'h00, sdaOe}, 8'h01);
      i_mst.bitx(1'b1, s);
      i_mst.stop();
      wr(`TMI_SLAVE_ADDR, 1'b1, `TMI_PTR_CONSEC, 1'b1, 8'h80);
      probe();
      wm(TO / 2);
      check("before expiry", {7'h00, sdaOe}, 8'h01);
      wm(TO / 2 + 100);
      check("after expiry", {7'h00, sdaOe}, 8'h00);
      i_mst.start();
      i_mst.stop();
      rd(`TMI_SLAVE_ADDR, 1'b1, 8'h80, 1'b1, 8'hFF);
      $display("test timeout finished");
      wm(100);
      check("pending notes", 8'(expQ.size()), 8'h00);
      endSim();
   end
endmodule
